// ===== inc/ipm_pkg.sv
package ipm_pkg;

    // configuration offsets
    localparam logic [7:0] OFS_WEIGHT     = 8'h68;
    localparam logic [7:0] OFS_IDLE_COUNT = 8'h6c;
    localparam logic [7:0] OFS_MSG_CTRL   = 8'h70;
    localparam logic [7:0] OFS_MSG_ADDR   = 8'h74;
    localparam logic [7:0] OFS_MSG_DATA   = 8'h78;
    localparam logic [7:0] OFS_IND_INDEX  = 8'h80;
    localparam logic [7:0] OFS_IND_DATA   = 8'h84;

    // reset values
    localparam logic [5:0]  RST_WEIGHT     = 6'h01;
    localparam logic [19:0] RST_IDLE_COUNT = 20'hfffff;
    localparam logic [31:0] RST_MSG_ADDR   = 32'h0000_0000;
    localparam logic [15:0] RST_MSG_DATA   = 16'h0000;
    localparam logic [8:0]  RST_IND_INDEX  = 9'h000;
    localparam logic [2:0]  RST_MSG_COUNT  = 3'h0;

    // idle count value that disables gating
    localparam logic [19:0] IDLE_GATE_OFF  = 20'hfffff;

    // fixed capability fields
    localparam logic [7:0]  CAP_ID         = 8'h05;
    localparam logic [7:0]  CAP_NEXT       = 8'h00;
    localparam logic [2:0]  GRANTED_COUNT  = 3'h0;
    localparam logic        ADDR64_CAP     = 1'b0;

    // field positions in the message control word
    localparam int          POS_MSG_EN     = 16;
    localparam int          POS_MSG_COUNT  = 17;
    localparam int          POS_GRANTED    = 20;
    localparam int          POS_ADDR64     = 23;

    // index field position
    localparam int          POS_INDEX      = 2;

    // full double-word byte enables
    localparam logic [3:0]  BE_FULL        = 4'hf;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_INDIRECT,
        ST_DONE
    } ipm_state_type;

endpackage

// ===== hw/ipm_idle_gate.sv
`timescale 1ns/1ps
module ipm_idle_gate (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic [19:0] limit,
    input  wire logic        limit_load,
    input  wire logic        bus_activity,
    output logic             gated
);

    logic [19:0] quiet;

    // quiet cycles since the last activity or count load, held at the limit
    always_ff @(posedge mclk) begin
        if (srst || bus_activity || limit_load) begin
            quiet <= 20'h00000;
        end else if (quiet != limit) begin
            quiet <= quiet + 20'h00001;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst || bus_activity || limit_load) begin
            gated <= 1'b0;
        end else if (limit != ipm_pkg::IDLE_GATE_OFF && quiet == limit) begin
            gated <= 1'b1;
        end
    end

    a_gate_never_off: assert property (@(posedge mclk) disable iff (srst)
        (limit == ipm_pkg::IDLE_GATE_OFF && !limit_load) |=> !gated)
        else $error("clock gated while gating disabled");

    a_activity_ungates: assert property (@(posedge mclk) disable iff (srst)
        bus_activity |=> !gated)
        else $error("activity did not restore clock");

    a_gate_on_limit: assert property (@(posedge mclk) disable iff (srst)
        (!gated && quiet == limit && limit != ipm_pkg::IDLE_GATE_OFF
         && !bus_activity && !limit_load) |=> gated)
        else $error("clock not gated at programmed count");

endmodule

// ===== hw/ipm_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - idle counter is 20 bits counting quiet time
// - gate controller clock after programmed quiet count
// - any bus activity restores clock immediately
// - count resets all ones, disabling gating
// - count updated only by double-word write
// - count measured in controller clocks after transaction
// - capability identifier reads fixed 05h
// - next pointer reads fixed 00h
// - granted message count reads zero
// - 64-bit address bit reads zero
// - message count capability resets to zero
// - 32-bit message address register, reset zero
// - 16-bit message data register, reset zero
// - 6-bit weight resets 01h, upper bits zero
// - reserved bits ignore writes, read zero
// - index holds dword index bits 10:2
// - data register accesses indexed double-word
// - combined mode selects config or memory window
// - message count writable only when enabled
module ipm_regs (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        cfg_req,
    input  wire logic        cfg_write,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [3:0]  cfg_byte_en,
    input  wire logic [31:0] cfg_wdata,
    output logic [31:0]      cfg_rdata,
    output logic             cfg_done,
    input  wire logic        bus_activity,
    output logic             ctrl_clk_enable,
    input  wire logic        combined_mode,
    input  wire logic        index_data_pair_mem,
    input  wire logic        msg_count_write_en,
    output logic             ind_req,
    output logic             ind_write,
    output logic             ind_sata_memory_window,
    output logic [8:0]       ind_index,
    output logic [31:0]      ind_wdata,
    input  wire logic [31:0] ind_rdata,
    input  wire logic        ind_ack,
    input  wire logic        dev_irq,
    output logic             legacy_irq,
    output logic             msg_wr_req,
    output logic [31:0]      msg_wr_addr,
    output logic [31:0]      msg_wr_data,
    input  wire logic        msg_wr_ack,
    output logic [5:0]       irq_weight
);

    logic [19:0]            idle_count;
    logic                   message_interrupt_enable;
    logic [2:0]             msg_count_cap;
    logic [31:0]            msg_addr;
    logic [15:0]            msg_data;
    logic [8:0]             index_reg;
    logic                   gated;
    logic                   dev_irq_q;
    logic                   msg_pending;
    logic [31:0]            next_rdata;
    logic                   wr_hit;
    logic                   rd_ok;
    logic                   idle_load;
    ipm_pkg::ipm_state_type state;
    logic                   hold_write;
    logic [31:0]            hold_wdata;

    // byte-wise merge of a write into a word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wdat,
                                          input logic [3:0]  be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wdat[i*8 +: 8];
            end
        end
        return res;
    endfunction

    assign rd_ok     = (state == ipm_pkg::ST_IDLE) && cfg_req;
    assign wr_hit    = rd_ok && cfg_write;
    assign idle_load = wr_hit && cfg_addr == ipm_pkg::OFS_IDLE_COUNT
                       && cfg_byte_en == ipm_pkg::BE_FULL;

    // request sequencing: indirect data goes out to the far space
    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= ipm_pkg::ST_IDLE;
        end else begin
            case (state)
                ipm_pkg::ST_IDLE: begin
                    if (cfg_req && cfg_addr == ipm_pkg::OFS_IND_DATA) begin
                        state <= ipm_pkg::ST_INDIRECT;
                    end else if (cfg_req) begin
                        state <= ipm_pkg::ST_DONE;
                    end
                end
                ipm_pkg::ST_INDIRECT: begin
                    if (ind_ack) begin
                        state <= ipm_pkg::ST_DONE;
                    end
                end
                ipm_pkg::ST_DONE: begin
                    state <= ipm_pkg::ST_IDLE;
                end
                default: begin
                    state <= ipm_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            hold_write <= 1'b0;
            hold_wdata <= 32'h0000_0000;
        end else if (rd_ok) begin
            hold_write <= cfg_write;
            hold_wdata <= cfg_wdata;
        end
    end

    // indirect access port
    assign ind_req   = (state == ipm_pkg::ST_INDIRECT);
    assign ind_write = hold_write;
    assign ind_wdata = hold_wdata;
    assign ind_index = index_reg;
    assign ind_sata_memory_window = combined_mode && index_data_pair_mem;

    always_ff @(posedge mclk) begin
        if (srst) begin
            cfg_done <= 1'b0;
        end else begin
            cfg_done <= (state == ipm_pkg::ST_DONE);
        end
    end

    // read data mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (cfg_addr == ipm_pkg::OFS_WEIGHT) begin
            next_rdata[5:0] = irq_weight;
        end else if (cfg_addr == ipm_pkg::OFS_IDLE_COUNT) begin
            next_rdata[19:0] = idle_count;
        end else if (cfg_addr == ipm_pkg::OFS_MSG_CTRL) begin
            next_rdata[7:0]   = ipm_pkg::CAP_ID;
            next_rdata[15:8]  = ipm_pkg::CAP_NEXT;
            next_rdata[ipm_pkg::POS_MSG_EN] = message_interrupt_enable;
            next_rdata[ipm_pkg::POS_MSG_COUNT +: 3] = msg_count_cap;
            next_rdata[ipm_pkg::POS_GRANTED +: 3]   = ipm_pkg::GRANTED_COUNT;
            next_rdata[ipm_pkg::POS_ADDR64]         = ipm_pkg::ADDR64_CAP;
        end else if (cfg_addr == ipm_pkg::OFS_MSG_ADDR) begin
            next_rdata = msg_addr;
        end else if (cfg_addr == ipm_pkg::OFS_MSG_DATA) begin
            next_rdata[15:0] = msg_data;
        end else if (cfg_addr == ipm_pkg::OFS_IND_INDEX) begin
            next_rdata[ipm_pkg::POS_INDEX +: 9] = index_reg;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cfg_rdata <= 32'h0000_0000;
        end else if (state == ipm_pkg::ST_INDIRECT && ind_ack && !hold_write) begin
            cfg_rdata <= ind_rdata;
        end else if (rd_ok && !cfg_write) begin
            cfg_rdata <= next_rdata;
        end
    end

    // register writes
    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_weight <= ipm_pkg::RST_WEIGHT;
        end else if (wr_hit && cfg_addr == ipm_pkg::OFS_WEIGHT && cfg_byte_en[0]) begin
            irq_weight <= cfg_wdata[5:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            idle_count <= ipm_pkg::RST_IDLE_COUNT;
        end else if (idle_load) begin
            idle_count <= cfg_wdata[19:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            message_interrupt_enable <= 1'b0;
            msg_count_cap            <= ipm_pkg::RST_MSG_COUNT;
        end else if (wr_hit && cfg_addr == ipm_pkg::OFS_MSG_CTRL && cfg_byte_en[2]) begin
            message_interrupt_enable <= cfg_wdata[ipm_pkg::POS_MSG_EN];
            if (msg_count_write_en) begin
                msg_count_cap <= cfg_wdata[ipm_pkg::POS_MSG_COUNT +: 3];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            msg_addr <= ipm_pkg::RST_MSG_ADDR;
        end else if (wr_hit && cfg_addr == ipm_pkg::OFS_MSG_ADDR) begin
            msg_addr <= merge(msg_addr, cfg_wdata, cfg_byte_en);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            msg_data <= ipm_pkg::RST_MSG_DATA;
        end else if (wr_hit && cfg_addr == ipm_pkg::OFS_MSG_DATA) begin
            msg_data <= 16'(merge({16'h0000, msg_data}, cfg_wdata,
                                  cfg_byte_en));
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            index_reg <= ipm_pkg::RST_IND_INDEX;
        end else if (wr_hit && cfg_addr == ipm_pkg::OFS_IND_INDEX) begin
            index_reg <= 9'(merge({21'h0, index_reg, 2'b00}, cfg_wdata,
                                  cfg_byte_en) >> ipm_pkg::POS_INDEX);
        end
    end

    // idle clock gating
    ipm_idle_gate u_idle_gate (
        .mclk         (mclk),
        .srst         (srst),
        .limit        (idle_count),
        .limit_load   (idle_load),
        .bus_activity (bus_activity),
        .gated        (gated)
    );

    assign ctrl_clk_enable = !gated || bus_activity;

    // interrupt delivery
    always_ff @(posedge mclk) begin
        if (srst) begin
            dev_irq_q  <= 1'b0;
            legacy_irq <= 1'b0;
        end else begin
            dev_irq_q  <= dev_irq;
            legacy_irq <= dev_irq && !message_interrupt_enable;
        end
    end

    // new edge wins over an acknowledge in the same cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            msg_pending <= 1'b0;
        end else if (dev_irq && !dev_irq_q && message_interrupt_enable) begin
            msg_pending <= 1'b1;
        end else if (msg_wr_ack) begin
            msg_pending <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            msg_wr_addr <= 32'h0000_0000;
            msg_wr_data <= 32'h0000_0000;
        end else if (!msg_pending) begin
            msg_wr_addr <= msg_addr;
            msg_wr_data <= {16'h0000, msg_data};
        end
    end

    assign msg_wr_req = msg_pending;

    a_ctrl_fixed: assert property (@(posedge mclk) disable iff (srst)
        (rd_ok && !cfg_write && cfg_addr == ipm_pkg::OFS_MSG_CTRL)
        |=> cfg_rdata[15:0] == 16'h0005 && cfg_rdata[31:23] == 9'h000)
        else $error("capability fields wrong");

    a_granted_zero: assert property (@(posedge mclk) disable iff (srst)
        (rd_ok && !cfg_write && cfg_addr == ipm_pkg::OFS_MSG_CTRL)
        |=> cfg_rdata[22:20] == 3'h0)
        else $error("granted message count not zero");

    a_narrow_no_count: assert property (@(posedge mclk) disable iff (srst)
        (wr_hit && cfg_addr == ipm_pkg::OFS_IDLE_COUNT && cfg_byte_en != 4'hf)
        |=> $stable(idle_count))
        else $error("narrow write changed idle count");

    a_count_guard: assert property (@(posedge mclk) disable iff (srst)
        (!msg_count_write_en) |=> $stable(msg_count_cap))
        else $error("message count changed while locked");

    a_weight_high: assert property (@(posedge mclk) disable iff (srst)
        (rd_ok && !cfg_write && cfg_addr == ipm_pkg::OFS_WEIGHT)
        |=> cfg_rdata[31:6] == 26'h0000000)
        else $error("weight upper bits not zero");

    a_index_low: assert property (@(posedge mclk) disable iff (srst)
        (rd_ok && !cfg_write && cfg_addr == ipm_pkg::OFS_IND_INDEX)
        |=> cfg_rdata[1:0] == 2'b00 && cfg_rdata[10:2] == $past(index_reg))
        else $error("index read wrong");

    a_indirect_read: assert property (@(posedge mclk) disable iff (srst)
        (ind_req && ind_ack && !ind_write) |=> cfg_rdata == $past(ind_rdata) ##1 cfg_done)
        else $error("indirect read data lost");

    a_window_route: assert property (@(posedge mclk) disable iff (srst)
        ind_req |-> ind_sata_memory_window == (combined_mode && index_data_pair_mem))
        else $error("indirect route wrong");

    a_msg_edge: assert property (@(posedge mclk) disable iff (srst)
        (dev_irq && !dev_irq_q && message_interrupt_enable) |=> msg_wr_req)
        else $error("message write not raised");

    a_reserved_idle: assert property (@(posedge mclk) disable iff (srst)
        (rd_ok && !cfg_write && cfg_addr == ipm_pkg::OFS_IDLE_COUNT)
        |=> cfg_rdata[31:20] == 12'h000)
        else $error("reserved idle bits not zero");

    a_full_write: assert property (@(posedge mclk) disable iff (srst)
        idle_load |=> idle_count == $past(cfg_wdata[19:0]))
        else $error("double-word write did not load idle count");

    a_weight_write: assert property (@(posedge mclk) disable iff (srst)
        (wr_hit && cfg_addr == ipm_pkg::OFS_WEIGHT && cfg_byte_en[0])
        |=> irq_weight == $past(cfg_wdata[5:0]))
        else $error("weight write lost");

    a_ind_held: assert property (@(posedge mclk) disable iff (srst)
        (ind_req && !ind_ack) |=> ind_req)
        else $error("indirect request dropped before acknowledge");

    a_msg_held: assert property (@(posedge mclk) disable iff (srst)
        (msg_wr_req && !msg_wr_ack)
        |=> msg_wr_req && $stable(msg_wr_addr) && $stable(msg_wr_data))
        else $error("message write changed before acknowledge");

    a_legacy_masked: assert property (@(posedge mclk) disable iff (srst)
        message_interrupt_enable |=> !legacy_irq)
        else $error("legacy line raised while message interrupts enabled");

endmodule

// ===== sim/ipm_far_model.sv
`timescale 1ns/1ps
module ipm_far_model (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic [3:0]  delay,
    input  wire logic        ind_req,
    input  wire logic        ind_write,
    input  wire logic        ind_sata_memory_window,
    input  wire logic [8:0]  ind_index,
    input  wire logic [31:0] ind_wdata,
    output logic [31:0]      ind_rdata,
    output logic             ind_ack
);
    logic [31:0] mem [0:1023];
    logic [3:0]  wait_cnt;

    always_ff @(posedge mclk) begin
        ind_ack   <= 1'b0;
        // stale read data scrambled except in reset and read ack cycles
        ind_rdata <= ~ind_rdata;
        if (srst) begin
            wait_cnt  <= 4'h0;
            ind_rdata <= 32'h5a5a_a5a5;
        end else if (ind_req && !ind_ack) begin
            if (wait_cnt == delay) begin
                wait_cnt <= 4'h0;
                ind_ack  <= 1'b1;
                if (ind_write) begin
                    mem[{ind_sata_memory_window, ind_index}] <= ind_wdata;
                end else begin
                    ind_rdata <= mem[{ind_sata_memory_window, ind_index}];
                end
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule

// ===== sim/ide_power_msi_index_regs_test.sv
`timescale 1ns/1ps
module ide_power_msi_index_regs_test;
    logic        mclk, srst, cfg_req, cfg_write, cfg_done, bus_activity, ctrl_clk_enable;
    logic        combined_mode, index_data_pair_mem, msg_count_write_en, ind_req, ind_write;
    logic        ind_sata_memory_window, ind_ack, dev_irq, legacy_irq, msg_wr_req, msg_wr_ack;
    logic [7:0]  cfg_addr;
    logic [3:0]  cfg_byte_en, delay;
    logic [31:0] cfg_wdata, cfg_rdata, ind_wdata, ind_rdata, msg_wr_addr, msg_wr_data;
    logic [8:0]  ind_index;
    logic [5:0]  irq_weight;
    int          fail_count;
    int          num_checks;

    ipm_regs DUT (.mclk(mclk), .srst(srst), .cfg_req(cfg_req), .cfg_write(cfg_write),
        .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_done(cfg_done), .bus_activity(bus_activity),
        .ctrl_clk_enable(ctrl_clk_enable), .combined_mode(combined_mode),
        .index_data_pair_mem(index_data_pair_mem), .msg_count_write_en(msg_count_write_en),
        .ind_req(ind_req), .ind_write(ind_write),
        .ind_sata_memory_window(ind_sata_memory_window), .ind_index(ind_index),
        .ind_wdata(ind_wdata), .ind_rdata(ind_rdata), .ind_ack(ind_ack), .dev_irq(dev_irq),
        .legacy_irq(legacy_irq), .msg_wr_req(msg_wr_req), .msg_wr_addr(msg_wr_addr),
        .msg_wr_data(msg_wr_data), .msg_wr_ack(msg_wr_ack), .irq_weight(irq_weight));

    ipm_far_model far (.mclk(mclk), .srst(srst), .delay(delay), .ind_req(ind_req),
        .ind_write(ind_write), .ind_sata_memory_window(ind_sata_memory_window),
        .ind_index(ind_index), .ind_wdata(ind_wdata), .ind_rdata(ind_rdata),
        .ind_ack(ind_ack));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic results();
        if (fail_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] wd, output logic [31:0] rdv);
        int n;
        n = 0;
        @(posedge mclk);
        cfg_req     <= 1'b1;
        cfg_write   <= w;
        cfg_addr    <= a;
        cfg_byte_en <= be;
        cfg_wdata   <= wd;
        @(posedge mclk);
        cfg_req <= 1'b0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (cfg_done !== 1'b1 && n < 60);
        rdv = cfg_rdata;
        if (n >= 60) begin
            fail_count++;
            results();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
        logic [31:0] dummy;
        cfg(1'b1, a, be, wd, dummy);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] rdv);
        cfg(1'b0, a, 4'hf, 32'h0, rdv);
    endtask

    task automatic t_reset();
        logic [31:0] v;
        chk({26'h0, irq_weight}, 32'h0000_0001);
        chk({31'h0, ctrl_clk_enable}, 32'h1);
        rd(ipm_pkg::OFS_WEIGHT, v);     chk(v, 32'h0000_0001);
        rd(ipm_pkg::OFS_IDLE_COUNT, v); chk(v, 32'h000f_ffff);
        rd(ipm_pkg::OFS_MSG_CTRL, v);   chk(v, 32'h0000_0005);
        rd(ipm_pkg::OFS_MSG_ADDR, v);   chk(v, 32'h0000_0000);
        rd(ipm_pkg::OFS_MSG_DATA, v);   chk(v, 32'h0000_0000);
        rd(ipm_pkg::OFS_IND_INDEX, v);  chk(v, 32'h0000_0000);
        wr(8'h7c, 4'hf, 32'hffff_ffff);
        rd(8'h7c, v);                   chk(v, 32'h0000_0000);
    endtask

    task automatic t_regs();
        logic [31:0] v;
        wr(ipm_pkg::OFS_WEIGHT, 4'hf, 32'hffff_ffff);
        rd(ipm_pkg::OFS_WEIGHT, v);    chk(v, 32'h0000_003f);
        chk({26'h0, irq_weight}, 32'h0000_003f);
        wr(ipm_pkg::OFS_MSG_ADDR, 4'hf, 32'ha5a5_0f0f);
        rd(ipm_pkg::OFS_MSG_ADDR, v);  chk(v, 32'ha5a5_0f0f);
        wr(ipm_pkg::OFS_MSG_DATA, 4'hf, 32'hffff_ffff);
        rd(ipm_pkg::OFS_MSG_DATA, v);  chk(v, 32'h0000_ffff);
        wr(ipm_pkg::OFS_IND_INDEX, 4'hf, 32'hffff_ffff);
        rd(ipm_pkg::OFS_IND_INDEX, v); chk(v, 32'h0000_07fc);
        wr(ipm_pkg::OFS_MSG_CTRL, 4'hf, 32'hffff_ffff);
        rd(ipm_pkg::OFS_MSG_CTRL, v);  chk(v, 32'h0001_0005);
        @(posedge mclk);
        msg_count_write_en <= 1'b1;
        wr(ipm_pkg::OFS_MSG_CTRL, 4'hf, 32'hffff_ffff);
        rd(ipm_pkg::OFS_MSG_CTRL, v);  chk(v, 32'h000f_0005);
        @(posedge mclk);
        msg_count_write_en <= 1'b0;
    endtask

    task automatic t_idle();
        logic [31:0] v;
        int          n;
        wr(ipm_pkg::OFS_IDLE_COUNT, 4'h7, 32'h0000_0020);
        rd(ipm_pkg::OFS_IDLE_COUNT, v); chk(v, 32'h000f_ffff);
        wr(ipm_pkg::OFS_IDLE_COUNT, 4'hf, 32'h0000_0020);
        rd(ipm_pkg::OFS_IDLE_COUNT, v); chk(v, 32'h0000_0020);
        @(posedge mclk);
        bus_activity <= 1'b1;
        @(posedge mclk);
        bus_activity <= 1'b0;
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (ctrl_clk_enable === 1'b1 && n < 80);
        if (n >= 80) begin
            fail_count++;
            results();
        end
        chk({31'h0, n >= 28 && n <= 36}, 32'h1);
        @(posedge mclk);
        bus_activity <= 1'b1;
        #1;
        chk({31'h0, ctrl_clk_enable}, 32'h1);
        @(posedge mclk);
        bus_activity <= 1'b0;
        #1;
        chk({31'h0, ctrl_clk_enable}, 32'h1);
        wr(ipm_pkg::OFS_IDLE_COUNT, 4'hf, 32'hffff_ffff);
        rd(ipm_pkg::OFS_IDLE_COUNT, v); chk(v, 32'h000f_ffff);
        repeat (60) @(posedge mclk);
        #1;
        chk({31'h0, ctrl_clk_enable}, 32'h1);
    endtask

    task automatic t_indirect();
        logic [31:0] v;
        @(posedge mclk);
        combined_mode       <= 1'b1;
        index_data_pair_mem <= 1'b1;
        delay               <= 4'h3;
        wr(ipm_pkg::OFS_IND_INDEX, 4'hf, 32'h0000_0010);
        wr(ipm_pkg::OFS_IND_DATA, 4'hf, 32'hcafe_0001);
        @(posedge mclk);
        index_data_pair_mem <= 1'b0;
        delay               <= 4'h0;
        wr(ipm_pkg::OFS_IND_DATA, 4'hf, 32'h1234_5678);
        @(posedge mclk);
        index_data_pair_mem <= 1'b1;
        rd(ipm_pkg::OFS_IND_DATA, v); chk(v, 32'hcafe_0001);
        @(posedge mclk);
        index_data_pair_mem <= 1'b0;
        rd(ipm_pkg::OFS_IND_DATA, v); chk(v, 32'h1234_5678);
        @(posedge mclk);
        combined_mode       <= 1'b0;
        index_data_pair_mem <= 1'b1;
        rd(ipm_pkg::OFS_IND_DATA, v); chk(v, 32'h1234_5678);
    endtask

    task automatic t_msg();
        int n;
        wr(ipm_pkg::OFS_MSG_ADDR, 4'hf, 32'h0000_1000);
        wr(ipm_pkg::OFS_MSG_DATA, 4'hf, 32'h0000_beef);
        wr(ipm_pkg::OFS_MSG_CTRL, 4'hf, 32'h0001_0000);
        @(posedge mclk);
        dev_irq <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (msg_wr_req !== 1'b1 && n < 10);
        if (n >= 10) begin
            fail_count++;
            results();
        end
        chk(msg_wr_addr, 32'h0000_1000);
        chk(msg_wr_data, 32'h0000_beef);
        chk({31'h0, legacy_irq}, 32'h0);
        repeat (3) @(posedge mclk);
        #1;
        chk({31'h0, msg_wr_req}, 32'h1);
        wr(ipm_pkg::OFS_MSG_ADDR, 4'hf, 32'h0000_2000);
        chk(msg_wr_addr, 32'h0000_1000);
        chk({31'h0, msg_wr_req}, 32'h1);
        @(posedge mclk);
        msg_wr_ack <= 1'b1;
        @(posedge mclk);
        msg_wr_ack <= 1'b0;
        dev_irq    <= 1'b0;
        @(posedge mclk);
        #1;
        chk({31'h0, msg_wr_req}, 32'h0);
        wr(ipm_pkg::OFS_MSG_CTRL, 4'hf, 32'h0000_0000);
        @(posedge mclk);
        dev_irq <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        chk({31'h0, legacy_irq}, 32'h1);
        chk({31'h0, msg_wr_req}, 32'h0);
        @(posedge mclk);
        dev_irq <= 1'b0;
    endtask

    // second reset in mid-run, registers other than the idle count hold non-reset values here
    task automatic t_rerst();
        logic [31:0] v;
        @(posedge mclk);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        #1;
        chk({26'h0, irq_weight}, 32'h0000_0001);
        rd(ipm_pkg::OFS_MSG_CTRL, v);   chk(v, 32'h0000_0005);
        rd(ipm_pkg::OFS_MSG_ADDR, v);   chk(v, 32'h0000_0000);
        rd(ipm_pkg::OFS_IDLE_COUNT, v); chk(v, 32'h000f_ffff);
    endtask

    initial begin
        fail_count = 0;
        num_checks = 0;
        srst = 1'b1;
        cfg_req = 1'b0;
        cfg_write = 1'b0;
        cfg_addr = 8'h00;
        cfg_byte_en = 4'h0;
        cfg_wdata = 32'h0;
        bus_activity = 1'b0;
        combined_mode = 1'b0;
        index_data_pair_mem = 1'b0;
        msg_count_write_en = 1'b0;
        dev_irq = 1'b0;
        msg_wr_ack = 1'b0;
        delay = 4'h0;
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        #1;
        t_reset();
        t_regs();
        t_idle();
        t_indirect();
        t_msg();
        t_rerst();
        results();
    end
endmodule
